//--- core/prc_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PRC_DEFS_SVH
`define PRC_DEFS_SVH
// ==========================================================
// Register offsets
`define PRC_OFS_EDGE_DELAY   8'h27
`define PRC_OFS_SLEEP_SEL    8'h29
`define PRC_OFS_OUT_CFG      8'h2A
`define PRC_OFS_SLAVE_ADDR   8'h2B
// ==========================================================
// Field positions
`define PRC_FALL_HI          5
`define PRC_FALL_LO          3
`define PRC_RISE_HI          2
`define PRC_RISE_LO          0
`define PRC_SRC_LO           4
`define PRC_ADDR_SEL_BIT     7
`define PRC_OUT_RSVD_BIT     3
// ==========================================================
// Reset values (factory values unknown, zero chosen) and default address 0x5E
`define PRC_RST_EDGE_DELAY   8'h00
`define PRC_RST_SLEEP_SEL    8'h00
`define PRC_RST_OUT_CFG      8'h00
`define PRC_RST_SLAVE_ADDR   8'h00
`define PRC_DEFAULT_ADDR     7'h5E
// ==========================================================
// Timing: base step 2 ms at 40 MHz
`define PRC_CLK_HZ           40000000
`define PRC_STEP_MS          2
`define PRC_STEP_CYCLES      ((`PRC_CLK_HZ / 1000) * `PRC_STEP_MS)
`endif

//--- core/prc_delay_if.sv
// Carrier between the register bank and the edge delay timer
`timescale 1ns/1ps
interface prc_delay_if;
   logic [2:0] fall_code;
   logic [2:0] rise_code;
   logic       enable_raw;
   logic       enable_out;
   modport bank  (output fall_code, output rise_code, output enable_raw, input enable_out);
   modport timer (input fall_code, input rise_code, input enable_raw, output enable_out);
endinterface : prc_delay_if

//--- core/prc_edge_delay.sv
// Enable edge delay timer for the switch/LDO pair
`timescale 1ns/1ps
`include "prc_defs.svh"
module prc_edge_delay
   import prc_pkg::*;
#(
   parameter int unsigned STEP_CYCLES = `PRC_STEP_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Link to bank
   prc_delay_if.timer dly
);
   // ==========================================================
   // Code to step count (one step = 2 ms)
   function automatic logic [5:0] steps(input logic [2:0] c);
      case (c)
         3'b001:  steps = 6'h01;
         3'b010:  steps = 6'h02;
         3'b011:  steps = 6'h04;
         3'b100:  steps = 6'h08;
         3'b101:  steps = 6'h0C;
         3'b110:  steps = 6'h10;
         3'b111:  steps = 6'h20;
         default: steps = 6'h00;
      endcase
   endfunction : steps

   prc_dly_state_t state;
   logic [5:0]     step_left;
   logic [21:0]    sub_cnt;
   logic           target;
   logic           want;
   logic [5:0]     want_steps;

   // Request differs from output; pick the delay of that edge
   always_comb begin
      want       = dly.enable_raw;
      want_steps = want ? steps(dly.rise_code) : steps(dly.fall_code);
   end

   // ==========================================================
   // Counter timing, output changes after elapsed count, or at once for a zero code
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state          <= PRC_IDLE;
         step_left      <= 6'h00;
         sub_cnt        <= 22'h000000;
         target         <= 1'b0;
         dly.enable_out <= 1'b0;
      end else begin
         case (state)
            PRC_IDLE: begin
               if (want != dly.enable_out) begin
                  if (want_steps == 6'h00) begin
                     dly.enable_out <= want;  // no delay code
                  end else begin
                     target    <= want;
                     step_left <= want_steps;
                     sub_cnt   <= 22'(STEP_CYCLES - 1);
                     state     <= PRC_WAIT;
                  end
               end
            end
            PRC_WAIT: begin
               if (want != target) begin
                  state <= PRC_IDLE;  // Edge withdrawn: restart
               end else if (sub_cnt != 22'h000000) begin
                  sub_cnt <= sub_cnt - 22'h000001;
               end else if (step_left != 6'h01) begin
                  step_left <= step_left - 6'h01;
                  sub_cnt   <= 22'(STEP_CYCLES - 1);
               end else begin
                  dly.enable_out <= target;  // exact nominal
                  state          <= PRC_IDLE;
               end
            end
            default: state <= PRC_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Assertions
   a_out_needs_wait: assert property (
      @(posedge mclk) disable iff (!rstn)
      $changed(dly.enable_out)
      |-> ($past(state) == PRC_IDLE && $past(want_steps) == 6'h00)
      || ($past(state) == PRC_WAIT && $past(step_left) == 6'h01
      && $past(sub_cnt) == 22'h000000))
      else $error("enable changed before delay elapsed");
   a_zero_code_fast: assert property (
      @(posedge mclk) disable iff (!rstn)
      (state == PRC_IDLE && want != dly.enable_out && want_steps == 6'h00)
      |=> dly.enable_out == $past(want))
      else $error("no-delay edge not passed at once");
   a_wait_steps_live: assert property (
      @(posedge mclk) disable iff (!rstn)
      state == PRC_WAIT |-> step_left != 6'h00)
      else $error("waiting with no steps left");
endmodule : prc_edge_delay

//--- core/prc_pkg.sv
// Types for the rail control register slice
package prc_pkg;
   typedef enum logic [1:0] {
      PRC_IDLE = 2'b00,
      PRC_WAIT = 2'b01
   } prc_dly_state_t;
   typedef logic [7:0] prc_byte_t;
endpackage : prc_pkg

//--- core/prc_rail_regs.sv
// Rail control configuration registers and their controlled outputs
// ==========================================================
// Overview of operation
// - Bits 5:3 of the delay register set the falling enable edge delay, 0 to 64 ms.
// - Bits 2:0 of the delay register set the rising enable edge delay, 0 to 64 ms.
// - Delay values are nominal and may differ by up to ten percent.
// - Each of eight rails takes its sleep request from pin three on 0, pin six on 1.
// - General outputs one to four follow power-good logic on 0, a register bit on 1.
// - General outputs one to three drive push-pull on 0 and open-drain on 1.
// - Address-select 0 answers at 0x5E, 1 answers at the programmed address.
// - Programmed addresses 0x09 to 0x37 and 0x39 to 0x77 are answered when selected.
// - The delayed enable comes from a pin multiplexer that may force a constant one.
`timescale 1ns/1ps
`include "prc_defs.svh"
module prc_rail_regs
   import prc_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rstn,
   // Register port from serial interface
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic      [6:0] bus_address,
   // Pair enable from multiplexer
   input  wire logic       pair_enable_in,
   output logic            switch_ldo_pair_en,
   // Sleep control pins
   input  wire logic       control_pin_three,
   input  wire logic       control_pin_six,
   output logic      [7:0] rail_sleep,
   // General outputs
   input  wire logic [3:0] power_good_logic,
   input  wire logic [3:0] output_register_value,
   output logic      [3:0] general_output_o,
   output logic      [3:0] general_output_oe
);
   // ==========================================================
   // Register storage
   prc_byte_t rail_pair_edge_delay;
   prc_byte_t sleep_pin_select;
   prc_byte_t general_output_config;
   prc_byte_t serial_slave_address;

   // Pin synchronisers
   logic [1:0] sync_en;
   logic [1:0] sync_p3;
   logic [1:0] sync_p6;
   logic [3:0] sync_pg_a;
   logic [3:0] sync_pg_b;

   prc_delay_if dly ();

   // Two-flop synchronisers on pins
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         sync_en   <= 2'h0;
         sync_p3   <= 2'h0;
         sync_p6   <= 2'h0;
         sync_pg_a <= 4'h0;
         sync_pg_b <= 4'h0;
      end else begin
         sync_en   <= {sync_en[0], pair_enable_in};
         sync_p3   <= {sync_p3[0], control_pin_three};
         sync_p6   <= {sync_p6[0], control_pin_six};
         sync_pg_a <= power_good_logic;
         sync_pg_b <= sync_pg_a;
      end
   end

   // ==========================================================
   // Register writes, all bits stored
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rail_pair_edge_delay  <= `PRC_RST_EDGE_DELAY;
         sleep_pin_select      <= `PRC_RST_SLEEP_SEL;
         general_output_config <= `PRC_RST_OUT_CFG;
         serial_slave_address  <= `PRC_RST_SLAVE_ADDR;
      end else if (reg_wr) begin
         case (reg_addr)
            `PRC_OFS_EDGE_DELAY: rail_pair_edge_delay  <= reg_wdata;
            `PRC_OFS_SLEEP_SEL:  sleep_pin_select      <= reg_wdata;
            `PRC_OFS_OUT_CFG:    general_output_config <= reg_wdata;
            `PRC_OFS_SLAVE_ADDR: serial_slave_address  <= reg_wdata;  // stored as given
            default: ;
         endcase
      end
   end

   // Read data, unmapped reads zero
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `PRC_OFS_EDGE_DELAY: reg_rdata <= rail_pair_edge_delay;
            `PRC_OFS_SLEEP_SEL:  reg_rdata <= sleep_pin_select;
            `PRC_OFS_OUT_CFG:    reg_rdata <= general_output_config;
            `PRC_OFS_SLAVE_ADDR: reg_rdata <= serial_slave_address;
            default:             reg_rdata <= 8'h00;
         endcase
      end
   end

   // ==========================================================
   // Address choice
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         bus_address <= `PRC_DEFAULT_ADDR;
      end else if (serial_slave_address[`PRC_ADDR_SEL_BIT]) begin
         bus_address <= serial_slave_address[6:0];
      end else begin
         bus_address <= `PRC_DEFAULT_ADDR;
      end
   end

   // ==========================================================
   // Edge delay timer hookup
   assign dly.fall_code  = rail_pair_edge_delay[`PRC_FALL_HI:`PRC_FALL_LO];
   assign dly.rise_code  = rail_pair_edge_delay[`PRC_RISE_HI:`PRC_RISE_LO];
   assign dly.enable_raw = sync_en[1];

   prc_edge_delay u_delay (
      .mclk (mclk),
      .rstn (rstn),
      .dly  (dly.timer)
   );

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         switch_ldo_pair_en <= 1'b0;
      end else begin
         switch_ldo_pair_en <= dly.enable_out;
      end
   end

   // ==========================================================
   // Sleep selection per rail
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rail_sleep <= 8'h00;
      end else begin
         for (int i = 0; i < 8; i++) begin
            rail_sleep[i] <= sleep_pin_select[i] ? sync_p6[1] : sync_p3[1];
         end
      end
   end

   // ==========================================================
   // General output source and drive type
   logic [3:0] gpo_level;
   logic [3:0] gpo_open_drain;

   // Level per output from its chosen source, drive type per output
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         gpo_level[i] = general_output_config[`PRC_SRC_LO + i] ?
                        output_register_value[i] : sync_pg_b[i];
      end
      gpo_open_drain = {1'b0, general_output_config[2:0]};  // output four push-pull
   end

   // Open drain only pulls low and releases for a high level
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         general_output_o  <= 4'h0;
         general_output_oe <= 4'h0;
      end else begin
         general_output_o  <= gpo_level & ~gpo_open_drain;
         general_output_oe <= ~gpo_open_drain | ~gpo_level;
      end
   end

   // ==========================================================
   // Assertions
   a_addr_default_sel: assert property (
      @(posedge mclk) disable iff (!rstn)
      !serial_slave_address[`PRC_ADDR_SEL_BIT] |=> bus_address == `PRC_DEFAULT_ADDR)
      else $error("default address not used");
   a_addr_prog_sel: assert property (
      @(posedge mclk) disable iff (!rstn)
      serial_slave_address[`PRC_ADDR_SEL_BIT]
      |=> bus_address == $past(serial_slave_address[6:0]))
      else $error("programmed address not used");
   a_sleep_pin_six: assert property (
      @(posedge mclk) disable iff (!rstn)
      sleep_pin_select[0] |=> rail_sleep[0] == $past(sync_p6[1]))
      else $error("sleep not from pin six");
   a_sleep_pin_three: assert property (
      @(posedge mclk) disable iff (!rstn)
      !sleep_pin_select[7] |=> rail_sleep[7] == $past(sync_p3[1]))
      else $error("sleep not from pin three");
   a_sleep_mid_rail: assert property (
      @(posedge mclk) disable iff (!rstn)
      sleep_pin_select[3] |=> rail_sleep[3] == $past(sync_p6[1]))
      else $error("rail three sleep not from pin six");
   a_gpo_reg_src: assert property (
      @(posedge mclk) disable iff (!rstn)
      general_output_config[7] |=> general_output_o[3] == $past(output_register_value[3]))
      else $error("output four not from register");
   a_gpo_pg_src: assert property (
      @(posedge mclk) disable iff (!rstn)
      !general_output_config[5] && !general_output_config[1]
      |=> general_output_o[1] == $past(sync_pg_b[1]))
      else $error("output two not from power good");
   a_gpo_open_drain: assert property (
      @(posedge mclk) disable iff (!rstn)
      general_output_config[0] |=> general_output_o[0] == 1'b0)
      else $error("open drain drove high");
   a_gpo_od_release: assert property (
      @(posedge mclk) disable iff (!rstn)
      general_output_config[2] && general_output_config[6]
      |=> general_output_oe[2] == !$past(output_register_value[2]))
      else $error("open drain enable wrong");
   a_gpo_push_pull: assert property (
      @(posedge mclk) disable iff (!rstn)
      !general_output_config[1] |=> general_output_oe[1])
      else $error("push-pull not driving");
   a_rsvd_no_effect: assert property (
      @(posedge mclk) disable iff (!rstn)
      $changed(general_output_config[`PRC_OUT_RSVD_BIT])
      && $stable(general_output_config[2:0]) && $stable(general_output_config[7:4])
      && $stable(sync_pg_b) && $stable(output_register_value)
      |=> $stable({general_output_oe, general_output_o}))
      else $error("reserved bit changed output");
   a_wr_all_bits: assert property (
      @(posedge mclk) disable iff (!rstn)
      reg_wr && reg_addr == `PRC_OFS_EDGE_DELAY
      |=> rail_pair_edge_delay == $past(reg_wdata))
      else $error("delay register lost written bits");
   a_rd_returns: assert property (
      @(posedge mclk) disable iff (!rstn)
      reg_rd && reg_addr == `PRC_OFS_EDGE_DELAY
      |=> reg_rdata == $past(rail_pair_edge_delay))
      else $error("read data not the stored value");
   a_pair_en_follow: assert property (
      @(posedge mclk) disable iff (!rstn)
      1'b1 |=> switch_ldo_pair_en == $past(dly.enable_out))
      else $error("pair enable not from timer");
endmodule : prc_rail_regs

//--- tb/prc_host_model.sv
// Host controller model driving the register port
`timescale 1ns/1ps
`include "prc_defs.svh"
module prc_host_model (
   // Clock
   input  wire logic       mclk,
   // Register port
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   // ==========================================================
   // Idle bus
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // One-cycle write, lines inverted once released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [6:0] v;
      v = d[6:0];
      // Addresses 0x00, 0x08, 0x38, 0x78 and 0x7F are never programmed
      if (a == `PRC_OFS_SLAVE_ADDR && (v == 7'h00 || v == 7'h08 || v == 7'h78
          || v == 7'h7F || v == 7'h38)) return;
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr
   // Read strobe, data taken one edge after it is accepted
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(posedge mclk);
      d = reg_rdata;
   endtask : rd
endmodule : prc_host_model

//--- tb/tb.sv
// Self-checking bench for the rail control register slice
`timescale 1ns/1ps
`include "prc_defs.svh"
module tb
   import prc_pkg::*;
;
   // ==========================================================
   // Signals
   logic       mclk = 1'b0;
   logic       rstn = 1'b0;
   logic       reg_wr, reg_rd, switch_ldo_pair_en;
   prc_byte_t  reg_addr, reg_wdata, reg_rdata, rail_sleep, res, e;
   logic [6:0] bus_address;
   logic       pair_enable_in = 1'b0;
   logic       control_pin_three = 1'b0;
   logic       control_pin_six = 1'b0;
   logic [3:0] power_good_logic = 4'h0;
   logic [3:0] output_register_value = 4'h0;
   logic [3:0] general_output_o, general_output_oe;
   logic       res_v = 1'b0;
   prc_byte_t  exp_q[$];
   prc_byte_t  atab[6] = '{8'h90, 8'h89, 8'hB7, 8'hB9, 8'hF7, 8'h40};
   int         errors = 0;
   int         n_checks = 0;
   int         seed = 3;
   // ==========================================================
   // Instances
   prc_host_model prc_host_model_i (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   prc_rail_regs prc_rail_regs_i (.mclk(mclk), .rstn(rstn), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .bus_address(bus_address),
      .pair_enable_in(pair_enable_in), .switch_ldo_pair_en(switch_ldo_pair_en),
      .control_pin_three(control_pin_three), .control_pin_six(control_pin_six),
      .rail_sleep(rail_sleep), .power_good_logic(power_good_logic),
      .output_register_value(output_register_value),
      .general_output_o(general_output_o), .general_output_oe(general_output_oe));
   // ==========================================================
   // Clock and watchdog
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      #2400000;
      errors++;
      print_verdict();
   end
   // Oldest note against each result
   always @(posedge mclk) begin
      if (res_v === 1'b1) begin
         e = exp_q.pop_front();
         n_checks++;
         if (res !== e) begin
            errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, res);
         end
      end
   end
   // ==========================================================
   // Tasks
   task automatic look(input prc_byte_t x, input prc_byte_t g);
      exp_q.push_back(x);
      res <= g;
      res_v <= 1'b1;
      @(posedge mclk);
      res_v <= 1'b0;
      @(posedge mclk);
   endtask : look
   task automatic rchk(input prc_byte_t a, input prc_byte_t x);
      prc_byte_t d;
      prc_host_model_i.rd(a, d);
      look(x, d);
   endtask : rchk
   task automatic wait_en(input logic v, input int n, output int k);
      k = 0;
      while (switch_ldo_pair_en !== v && k < n) begin
         @(posedge mclk);
         k++;
      end
   endtask : wait_en
   task automatic print_verdict();
      if (errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict
   // ==========================================================
   // Scenarios
   initial begin
      prc_byte_t  s, c, d;
      logic       a, b;
      logic [3:0] lv, o, oe;
      int         k;
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      // Reset contents, unmapped read and default address
      for (int i = 8'h27; i <= 8'h2B; i++) rchk(8'(i), 8'h00);
      look(8'h5E, {1'b0, bus_address});
      // Readback with reserved bits, unmapped write dropped
      repeat (4) begin
         d = 8'($random(seed));
         prc_host_model_i.wr(8'h28, d);
         rchk(8'h28, 8'h00);
         prc_host_model_i.wr(`PRC_OFS_EDGE_DELAY, d);
         rchk(`PRC_OFS_EDGE_DELAY, d);
      end
      // Sleep source per rail
      repeat (6) begin
         s = 8'($random(seed));
         {a, b} = 2'($random(seed));
         prc_host_model_i.wr(`PRC_OFS_SLEEP_SEL, s);
         control_pin_three <= a;
         control_pin_six <= b;
         rchk(`PRC_OFS_SLEEP_SEL, s);
         look((s & {8{b}}) | (~s & {8{a}}), rail_sleep);
      end
      // Output source and drive type
      repeat (8) begin
         c = 8'($random(seed));
         prc_host_model_i.wr(`PRC_OFS_OUT_CFG, c);
         {power_good_logic, output_register_value} <= 8'($random(seed));
         repeat (4) @(posedge mclk);
         lv = (c[7:4] & output_register_value) | (~c[7:4] & power_good_logic);
         o = lv & ~{1'b0, c[2:0]};
         oe = ~{1'b0, c[2:0]} | ~lv;
         look({oe, o}, {general_output_oe, general_output_o});
         // Flip only the reserved bit: outputs must not move
         prc_host_model_i.wr(`PRC_OFS_OUT_CFG, c ^ 8'h08);
         repeat (4) @(posedge mclk);
         look({oe, o}, {general_output_oe, general_output_o});
      end
      // Address source and programmed range edges
      foreach (atab[i]) begin
         prc_host_model_i.wr(`PRC_OFS_SLAVE_ADDR, atab[i]);
         repeat (2) @(posedge mclk);
         look(atab[i][7] ? {1'b0, atab[i][6:0]} : 8'h5E, {1'b0, bus_address});
      end
      // No delay on rise
      prc_host_model_i.wr(`PRC_OFS_EDGE_DELAY, 8'h00);
      pair_enable_in <= 1'b1;
      wait_en(1'b1, 8, k);
      look(8'h01, 8'(k < 8));
      // Fall delayed, then cancelled by a new rise
      prc_host_model_i.wr(`PRC_OFS_EDGE_DELAY, 8'h08);
      pair_enable_in <= 1'b0;
      repeat (100) @(posedge mclk);
      pair_enable_in <= 1'b1;
      look(8'h01, {7'h00, switch_ldo_pair_en});
      // No delay on fall, then a 2 ms rise
      prc_host_model_i.wr(`PRC_OFS_EDGE_DELAY, 8'h01);
      pair_enable_in <= 1'b0;
      wait_en(1'b0, 8, k);
      look(8'h01, 8'(k < 8));
      pair_enable_in <= 1'b1;
      repeat (72000) @(posedge mclk);
      look(8'h00, {7'h00, switch_ldo_pair_en});
      wait_en(1'b1, 16000, k);
      look(8'h01, 8'(k < 16000));
      print_verdict();
   end
endmodule : tb
